// >>> common/sbmc_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB words, pclk at 250 MHz
// Notes:   Definitions only
`ifndef SBMC_PARAMS_SVH
`define SBMC_PARAMS_SVH
// ****************************************
// Register offsets
// ****************************************
`define SBMC_OFF_CTRL    8'h00
`define SBMC_OFF_STAT    8'h04
`define SBMC_OFF_MODE    8'h08
`define SBMC_OFF_LPOFF   8'h0c
`define SBMC_OFF_STBYSP  8'h10
`define SBMC_OFF_ACTUAL  8'h14
// ****************************************
// Control fields and reset values
// ****************************************
`define SBMC_CTRL_INV    0
`define SBMC_CTRL_LPEN   1
`define SBMC_CTRL_UOREQ  2
`define SBMC_CTRL_LPSEL  3
`define SBMC_CTRL_DLY    4
`define SBMC_DLY_RESET   2'h1
`define SBMC_LPOFF_UO    8
`define SBMC_CODE_DEFLT  4'h8
// ****************************************
// Timing
// ****************************************
`define SBMC_CLK_HZ      250000000
`define SBMC_SLOW_HZ     32768
`define SBMC_TICK_CYCLES (`SBMC_CLK_HZ / `SBMC_SLOW_HZ)
`define SBMC_SETTLE_US   3000
`define SBMC_SETTLE_TICKS ((`SBMC_SETTLE_US * `SBMC_SLOW_HZ) / 1000000)
`endif

// >>> common/sbmc_pkg.sv
// Purpose: Types shared by the standby and buck mode control
// Assumes: Nothing
// Notes:   Modes are Gray along PULSE_FREQUENCY_MODE, AUTO_PULSE_SKIP, PWM
package sbmc_pkg;
  typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_PFM = 2'h1, MODE_APS = 2'h3, MODE_PWM = 2'h2} sbmc_mode_e;
  typedef enum logic [2:0] {PWR_OFF = 3'h0, PWR_STARTUP = 3'h1, PWR_ON = 3'h3, PWR_WATCHDOG = 3'h2,
                            PWR_MEMHOLD = 3'h6, PWR_USEROFF = 3'h7} sbmc_pwr_e;
  typedef enum logic [1:0] {SS_IDLE = 2'h0, SS_RAMP = 2'h1, SS_SETTLE = 2'h3, SS_DONE = 2'h2} sbmc_ss_e;
endpackage : sbmc_pkg

// >>> common/sbmc_mode_if.sv
// Purpose: Carries mode codes to the decoder and decoded modes back
// Assumes: Four-bit code per regulator
// Notes:   One entry per regulator
interface sbmc_mode_if #(parameter int NUM_REG = 6);
  logic [4*NUM_REG-1:0]   code;
  sbmc_pkg::sbmc_mode_e   normal_mode [NUM_REG];
  sbmc_pkg::sbmc_mode_e   standby_mode [NUM_REG];
  logic [NUM_REG-1:0]     reserved;
  modport dec (input code, output normal_mode, output standby_mode, output reserved);
  modport ctl (output code, input normal_mode, input standby_mode, input reserved);
endinterface : sbmc_mode_if

// >>> src/sbmc_mode_decode.sv
// Purpose: Decodes each regulator mode code into normal and standby modes
// Assumes: Reserved codes leave the regulator off
// Notes:   Purely combinational
module sbmc_mode_decode #(parameter int NUM_REG = 6)
(
  sbmc_mode_if.dec  mif
);
  // ****************************************
  // Per regulator decode
  // ****************************************
  for (genvar i = 0; i < NUM_REG; i++)
  begin : g_dec
    // Code table
    always_comb
    begin
      mif.reserved[i] = 1'b0;
      unique case (mif.code[4*i +: 4])
        4'h0: begin mif.normal_mode[i] = sbmc_pkg::MODE_OFF; mif.standby_mode[i] = sbmc_pkg::MODE_OFF; end
        4'h1: begin mif.normal_mode[i] = sbmc_pkg::MODE_PWM; mif.standby_mode[i] = sbmc_pkg::MODE_OFF; end
        4'h3: begin mif.normal_mode[i] = sbmc_pkg::MODE_PFM; mif.standby_mode[i] = sbmc_pkg::MODE_OFF; end
        4'h4: begin mif.normal_mode[i] = sbmc_pkg::MODE_APS; mif.standby_mode[i] = sbmc_pkg::MODE_OFF; end
        4'h5: begin mif.normal_mode[i] = sbmc_pkg::MODE_PWM; mif.standby_mode[i] = sbmc_pkg::MODE_PWM; end
        4'h6: begin mif.normal_mode[i] = sbmc_pkg::MODE_PWM; mif.standby_mode[i] = sbmc_pkg::MODE_APS; end
        4'h7: begin mif.normal_mode[i] = sbmc_pkg::MODE_OFF; mif.standby_mode[i] = sbmc_pkg::MODE_OFF; end
        4'h8: begin mif.normal_mode[i] = sbmc_pkg::MODE_APS; mif.standby_mode[i] = sbmc_pkg::MODE_APS; end
        4'hc: begin mif.normal_mode[i] = sbmc_pkg::MODE_APS; mif.standby_mode[i] = sbmc_pkg::MODE_PFM; end
        4'hd: begin mif.normal_mode[i] = sbmc_pkg::MODE_PWM; mif.standby_mode[i] = sbmc_pkg::MODE_PFM; end
        4'hf: begin mif.normal_mode[i] = sbmc_pkg::MODE_PFM; mif.standby_mode[i] = sbmc_pkg::MODE_PFM; end
        default:
        begin
          mif.normal_mode[i]  = sbmc_pkg::MODE_OFF; // Reserved code
          mif.standby_mode[i] = sbmc_pkg::MODE_OFF;
          mif.reserved[i]     = 1'b1;
        end
      endcase
    end
  end
endmodule : sbmc_mode_decode

// >>> src/sbmc_top.sv
// Purpose: Standby decode, standby delay and buck mode selection
// Assumes: pwr_state comes from the power sequencer on pclk
// Notes:   Slow rate is a one-cycle enable from a divider of pclk
//
// Added by the designer: the register addresses and the APB interface to the registers.
`include "sbmc_params.svh"

module sbmc_top #(
  parameter int NUM_REG     = 6,
  parameter int TICK_CYCLES = `SBMC_TICK_CYCLES,
  parameter int SETTLE_TICKS = `SBMC_SETTLE_TICKS,
  parameter logic [19:0] SETPT_TABLE = 20'h8a4e2
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  standby_pin,
  input  wire logic [1:0]            powerup_mode_select_pins,
  input  wire logic [NUM_REG-1:0]    reg_in_regulation,
  input  wire sbmc_pkg::sbmc_pwr_e   pwr_state,
  input  wire logic [NUM_REG-1:0]    startup_slot,
  output logic                       user_off_cmd,
  output logic                       user_off_memhold,
  output logic                       pll_enable,
  output logic [NUM_REG-1:0]         reg_enable,
  output logic [NUM_REG-1:0]         reg_discharge,
  output logic [NUM_REG-1:0]         reg_use_standby_setpoint,
  output logic [2*NUM_REG-1:0]       reg_mode,
  output logic [5*NUM_REG-1:0]       regulator_standby_setpoint
);
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int SW = $clog2(SETTLE_TICKS + 1);

  // Parameter checks
  if (NUM_REG < 1 || NUM_REG > 6 || TICK_CYCLES < 2 || SETTLE_TICKS < 1)
  begin : g_chk
    $error("sbmc_top: unsupported parameter value");
  end

  // ****************************************
  // Slow tick divider
  // ****************************************
  logic [TW-1:0] div_ff, nxt_div;
  logic          tick;

  // Counts one slow period of pclk
  always_comb
  begin
    tick    = (div_ff == TW'(TICK_CYCLES - 1));
    nxt_div = tick ? '0 : div_ff + TW'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) div_ff <= '0;
    else          div_ff <= nxt_div;
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic                 stby_s1_ff, stby_s2_ff;
  logic [1:0]           pums_s1_ff, pums_s2_ff;
  logic [NUM_REG-1:0]   reg_s1_ff, reg_s2_ff;

  // Two flops before any logic reads a pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stby_s1_ff <= 1'b0;
      stby_s2_ff <= 1'b0;
      pums_s1_ff <= 2'h0;
      pums_s2_ff <= 2'h0;
      reg_s1_ff  <= '0;
      reg_s2_ff  <= '0;
    end
    else
    begin
      stby_s1_ff <= standby_pin;
      stby_s2_ff <= stby_s1_ff;
      pums_s1_ff <= powerup_mode_select_pins;
      pums_s2_ff <= pums_s1_ff;
      reg_s1_ff  <= reg_in_regulation;
      reg_s2_ff  <= reg_s1_ff;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic                 inv_ff, nxt_inv;
  logic                 lpen_ff, nxt_lpen;
  logic                 lpsel_ff, nxt_lpsel;
  logic                 uoreq_ff, nxt_uoreq;
  logic [1:0]           dly_ff, nxt_dly;
  logic [4*NUM_REG-1:0] code_ff, nxt_code;
  logic [NUM_REG-1:0]   mh_ff, nxt_mh, uo_ff, nxt_uo;
  logic [5*NUM_REG-1:0] sp_ff, nxt_sp;
  logic [1:0]           boot_ff, nxt_boot;
  sbmc_pkg::sbmc_pwr_e  pwr_prev_ff;
  logic [31:0]          rd_ff, nxt_rd;
  logic                 wr_en, reload, mapped;
  logic [31:0]          stat_word, act_word;
  logic [4:0]           pums_sp;

  // Decode, writes and pin reload
  always_comb
  begin
    wr_en     = psel & penable & pwrite;
    mapped    = (paddr == `SBMC_OFF_CTRL) || (paddr == `SBMC_OFF_STAT) || (paddr == `SBMC_OFF_MODE) ||
                (paddr == `SBMC_OFF_LPOFF) || (paddr == `SBMC_OFF_STBYSP) || (paddr == `SBMC_OFF_ACTUAL);
    reload    = (boot_ff != 2'h0) || (pwr_state == sbmc_pkg::PWR_STARTUP && pwr_prev_ff != sbmc_pkg::PWR_STARTUP);
    nxt_boot  = (boot_ff == 2'h0) ? 2'h0 : boot_ff - 2'h1; // Last reload sees synced straps
    pums_sp   = SETPT_TABLE[5*pums_s2_ff +: 5];
    nxt_inv   = inv_ff;
    nxt_lpen  = lpen_ff;
    nxt_lpsel = lpsel_ff;
    nxt_dly   = dly_ff;
    nxt_code  = code_ff;
    nxt_mh    = mh_ff;
    nxt_uo    = uo_ff;
    nxt_sp    = sp_ff;
    nxt_uoreq = 1'b0;
    if (wr_en && paddr == `SBMC_OFF_CTRL)
    begin
      nxt_inv   = pwdata[`SBMC_CTRL_INV];
      nxt_lpen  = pwdata[`SBMC_CTRL_LPEN];
      nxt_lpsel = pwdata[`SBMC_CTRL_LPSEL];
      nxt_uoreq = pwdata[`SBMC_CTRL_UOREQ]; // Self-clearing command
      nxt_dly   = pwdata[`SBMC_CTRL_DLY +: 2];
    end
    if (wr_en && paddr == `SBMC_OFF_MODE)   nxt_code = pwdata[4*NUM_REG-1:0];
    if (wr_en && paddr == `SBMC_OFF_LPOFF)
    begin
      nxt_mh = pwdata[NUM_REG-1:0];
      nxt_uo = pwdata[`SBMC_LPOFF_UO +: NUM_REG];
    end
    if (wr_en && paddr == `SBMC_OFF_STBYSP) nxt_sp = pwdata[5*NUM_REG-1:0];
    if (reload)
    begin
      nxt_code = {NUM_REG{`SBMC_CODE_DEFLT}}; // Pin default, AUTO_PULSE_SKIP
      nxt_sp   = {NUM_REG{pums_sp}};
    end
    // Read data latched in the setup phase
    nxt_rd = rd_ff;
    if (psel && !penable)
    begin
      unique case (paddr)
        `SBMC_OFF_CTRL:   nxt_rd = {26'h0, dly_ff, lpsel_ff, 1'b0, lpen_ff, inv_ff};
        `SBMC_OFF_STAT:   nxt_rd = stat_word;
        `SBMC_OFF_MODE:   nxt_rd = 32'(code_ff); // Programmed, not actual
        `SBMC_OFF_LPOFF:  nxt_rd = 32'({uo_ff, 8'(mh_ff)});
        `SBMC_OFF_STBYSP: nxt_rd = 32'(sp_ff);
        `SBMC_OFF_ACTUAL: nxt_rd = act_word;
        default:          nxt_rd = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inv_ff      <= 1'b0;
      lpen_ff     <= 1'b0;
      lpsel_ff    <= 1'b0;
      uoreq_ff    <= 1'b0;
      dly_ff      <= `SBMC_DLY_RESET;
      code_ff     <= {NUM_REG{`SBMC_CODE_DEFLT}};
      mh_ff       <= '0;
      uo_ff       <= '0;
      sp_ff       <= '0;
      boot_ff     <= 2'h3;
      pwr_prev_ff <= sbmc_pkg::PWR_OFF;
      rd_ff       <= 32'h0;
    end
    else
    begin
      inv_ff      <= nxt_inv;
      lpen_ff     <= nxt_lpen;
      lpsel_ff    <= nxt_lpsel;
      uoreq_ff    <= nxt_uoreq;
      dly_ff      <= nxt_dly;
      code_ff     <= nxt_code;
      mh_ff       <= nxt_mh;
      uo_ff       <= nxt_uo;
      sp_ff       <= nxt_sp;
      boot_ff     <= nxt_boot;
      pwr_prev_ff <= pwr_state;
      rd_ff       <= nxt_rd;
    end
  end

  // APB answer, zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rd_ff;

  // ****************************************
  // Standby qualification and delay
  // ****************************************
  logic       smp_ff, nxt_smp;
  logic       act_ff, nxt_act;
  logic [1:0] cnt_ff, nxt_cnt;
  logic       decoded, lp_stby;

  // Sample on tick, XOR polarity, delay entry only
  always_comb
  begin
    nxt_smp = tick ? stby_s2_ff : smp_ff;
    decoded = smp_ff ^ inv_ff;
    nxt_act = act_ff;
    nxt_cnt = cnt_ff;
    if (pwr_state != sbmc_pkg::PWR_ON || !decoded)
    begin
      nxt_act = 1'b0;
      nxt_cnt = 2'h0;
    end
    else if (!act_ff && cnt_ff == 2'h0)
    begin
      nxt_act = (dly_ff == 2'h0);
      nxt_cnt = dly_ff;
    end
    else if (!act_ff && tick)
    begin
      nxt_cnt = cnt_ff - 2'h1;
      nxt_act = (cnt_ff == 2'h1);
    end
    lp_stby = act_ff & lpen_ff;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smp_ff <= 1'b0;
      act_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      smp_ff <= nxt_smp;
      act_ff <= nxt_act;
      cnt_ff <= nxt_cnt;
    end
  end

  assign pll_enable       = ~lp_stby;
  assign user_off_cmd     = uoreq_ff;
  assign user_off_memhold = lpsel_ff;
  assign stat_word        = {28'h0, (cnt_ff != 2'h0), ~lp_stby, act_ff, decoded};

  // ****************************************
  // Mode decoder
  // ****************************************
  sbmc_mode_if #(.NUM_REG(NUM_REG)) mif ();
  assign mif.code = code_ff;

  sbmc_mode_decode #(.NUM_REG(NUM_REG)) u_dec
  (
    .mif (mif.dec)
  );

  // ****************************************
  // Per regulator mode selection
  // ****************************************
  logic [2*NUM_REG-1:0] act_modes;
  assign act_word = 32'({2'h0, reg_enable, 4'h0, act_modes});

  for (genvar i = 0; i < NUM_REG; i++)
  begin : g_reg
    logic                 held_ff, nxt_held;
    logic                 start_ff, nxt_start;
    sbmc_pkg::sbmc_ss_e   ss_ff, nxt_ss;
    sbmc_pkg::sbmc_mode_e ramp_ff, nxt_ramp, target, final_mode;
    logic [SW-1:0]        sc_ff, nxt_sc;
    logic                 use_sb, lp_state;

    // Target mode from power state
    always_comb
    begin
      lp_state = (pwr_state == sbmc_pkg::PWR_MEMHOLD) || (pwr_state == sbmc_pkg::PWR_USEROFF);
      target   = sbmc_pkg::MODE_OFF;
      use_sb   = 1'b0;
      nxt_held = held_ff;
      nxt_start = start_ff;
      unique case (pwr_state)
        sbmc_pkg::PWR_MEMHOLD:
        begin
          target   = mh_ff[i] ? sbmc_pkg::MODE_PFM : sbmc_pkg::MODE_OFF;
          use_sb   = 1'b1;
          nxt_held = mh_ff[i];
          nxt_start = 1'b0;
        end
        sbmc_pkg::PWR_USEROFF:
        begin
          target   = uo_ff[i] ? sbmc_pkg::MODE_PFM : sbmc_pkg::MODE_OFF;
          use_sb   = 1'b1;
          nxt_held = uo_ff[i];
          nxt_start = 1'b0;
        end
        sbmc_pkg::PWR_STARTUP:
        begin
          if (startup_slot[i])
          begin
            nxt_start = 1'b1;
            nxt_held  = 1'b0;
          end
          if (start_ff)
            target = mif.normal_mode[i];                                 // Standby ignored
          else if (held_ff)
          begin
            target = sbmc_pkg::MODE_PFM;                                 // Kept on
            use_sb = 1'b1;
          end
        end
        sbmc_pkg::PWR_ON, sbmc_pkg::PWR_WATCHDOG:
        begin
          if (start_ff)
          begin
            target = act_ff ? mif.standby_mode[i] : mif.normal_mode[i];
            use_sb = act_ff;
          end
        end
        sbmc_pkg::PWR_OFF:
        begin
          nxt_held  = 1'b0;
          nxt_start = 1'b0;
        end
      endcase
    end

    // Soft-start ramp and settle
    always_comb
    begin
      nxt_ss   = ss_ff;
      nxt_ramp = ramp_ff;
      nxt_sc   = sc_ff;
      unique case (ss_ff)
        sbmc_pkg::SS_IDLE:
        begin
          nxt_ramp = sbmc_pkg::MODE_PFM;
          nxt_sc   = '0;
          if (target != sbmc_pkg::MODE_OFF)
            nxt_ss = held_ff && !lp_state ? sbmc_pkg::SS_DONE : sbmc_pkg::SS_RAMP;
        end
        sbmc_pkg::SS_RAMP:
        begin
          if (tick && ramp_ff == sbmc_pkg::MODE_PFM) nxt_ramp = sbmc_pkg::MODE_APS;
          if (tick && ramp_ff == sbmc_pkg::MODE_APS) nxt_ramp = sbmc_pkg::MODE_PWM;
          if (reg_s2_ff[i]) nxt_ss = sbmc_pkg::SS_SETTLE;
        end
        sbmc_pkg::SS_SETTLE:
        begin
          if (tick)
            nxt_sc = sc_ff + SW'(1);
          if (tick && sc_ff == SW'(SETTLE_TICKS - 1))
            nxt_ss = sbmc_pkg::SS_DONE;
        end
        sbmc_pkg::SS_DONE:
        begin
          nxt_sc = '0;
        end
      endcase
      if (target == sbmc_pkg::MODE_OFF)
        nxt_ss = sbmc_pkg::SS_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        held_ff  <= 1'b0;
        start_ff <= 1'b0;
        ss_ff    <= sbmc_pkg::SS_IDLE;
        ramp_ff  <= sbmc_pkg::MODE_PFM;
        sc_ff    <= '0;
      end
      else
      begin
        held_ff  <= nxt_held;
        start_ff <= nxt_start;
        ss_ff    <= nxt_ss;
        ramp_ff  <= nxt_ramp;
        sc_ff    <= nxt_sc;
      end
    end

    // Applied mode: ramp step until settled, AUTO_PULSE_SKIP left to the stage
    assign final_mode = (target == sbmc_pkg::MODE_OFF) ? sbmc_pkg::MODE_OFF :
                        (ss_ff == sbmc_pkg::SS_DONE || lp_state) ? target : // Low-power off holds PULSE_FREQUENCY_MODE
                        (ss_ff == sbmc_pkg::SS_IDLE) ? sbmc_pkg::MODE_PFM : ramp_ff;
    assign reg_mode[2*i +: 2]                  = final_mode;
    assign act_modes[2*i +: 2]                 = final_mode;
    assign reg_enable[i]                       = (final_mode != sbmc_pkg::MODE_OFF);
    assign reg_discharge[i]                    = (final_mode == sbmc_pkg::MODE_OFF);
    assign reg_use_standby_setpoint[i]         = use_sb;
    assign regulator_standby_setpoint[5*i +: 5] = sp_ff[5*i +: 5];
  end
endmodule : sbmc_top

// >>> test/sbmc_assertions.sv
// Purpose: Port checks of standby and mode control
// Assumes: Applied modes settle within three cycles
// Notes:   Bound to the top module below
module sbmc_assertions #(parameter int NUM_REG = 6)
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire sbmc_pkg::sbmc_pwr_e  pwr_state,
  input wire logic [NUM_REG-1:0]   startup_slot,
  input wire logic                 user_off_cmd,
  input wire logic                 pll_enable,
  input wire logic [NUM_REG-1:0]   reg_enable,
  input wire logic [NUM_REG-1:0]   reg_discharge,
  input wire logic [NUM_REG-1:0]   reg_use_standby_setpoint,
  input wire logic [2*NUM_REG-1:0] reg_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_REG-1:0] hi_bits;
  logic [NUM_REG-1:0] on_bits;
  // High bit set means AUTO_PULSE_SKIP or PWM
  always_comb
  begin
    for (int i = 0; i < NUM_REG; i++)
    begin
      hi_bits[i] = reg_mode[2*i+1];
      on_bits[i] = |reg_mode[2*i +: 2];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  disch_inv_a: assert property (reg_discharge == ~reg_enable)
    else $error("discharge not inverse");
  enable_mode_a: assert property (reg_enable == on_bits)
    else $error("enable not from mode");
  uo_pulse_a: assert property (psel && penable && pwrite && paddr == 8'h00 && pwdata[2] |=> user_off_cmd)
    else $error("no user off pulse");
  uo_single_a: assert property (user_off_cmd |=> !user_off_cmd)
    else $error("user off pulse too long");
  pll_on_only_a: assert property (!pll_enable |-> pwr_state == sbmc_pkg::PWR_ON ||
    $past(pwr_state) == sbmc_pkg::PWR_ON || $past(pwr_state, 2) == sbmc_pkg::PWR_ON)
    else $error("pll off outside on");
  memhold_mode_a: assert property ((pwr_state == sbmc_pkg::PWR_MEMHOLD) [*3] |-> hi_bits == '0)
    else $error("memhold mode not off or pfm");
  useroff_mode_a: assert property ((pwr_state == sbmc_pkg::PWR_USEROFF) [*3] |-> hi_bits == '0)
    else $error("useroff mode not off or pfm");
  lpoff_setpt_a: assert property ((pwr_state inside {sbmc_pkg::PWR_MEMHOLD, sbmc_pkg::PWR_USEROFF}) [*3]
    |-> (reg_enable & ~reg_use_standby_setpoint) == '0)
    else $error("standby set point unused");
  slot_ramp_a: assert property (pwr_state == sbmc_pkg::PWR_STARTUP && startup_slot[0] && !reg_enable[0]
    |=> reg_mode[1:0] == sbmc_pkg::MODE_PFM)
    else $error("start not in pfm");
endmodule : sbmc_assertions

bind sbmc_top sbmc_assertions #(.NUM_REG(NUM_REG)) i_sbmc_assertions (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pwr_state(pwr_state),
  .startup_slot(startup_slot), .user_off_cmd(user_off_cmd), .pll_enable(pll_enable), .reg_enable(reg_enable),
  .reg_discharge(reg_discharge), .reg_use_standby_setpoint(reg_use_standby_setpoint), .reg_mode(reg_mode));

// >>> test/sbmc_host_model.sv
// Purpose: Host side driving the standby pin
// Assumes: Host changes the pin just after a rising edge
// Notes:   Pin always has a defined level
module sbmc_host_model
(
  input  wire logic pclk,
  input  wire logic sleep_req,
  output logic      standby_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial standby_pin = 1'b0;
  // Pin follows the sleep request one edge later
  always @(posedge pclk)
  begin
    standby_pin <= sleep_req;
  end
endmodule : sbmc_host_model

// >>> test/standby_buck_mode_control_bench.sv
// Purpose: Drives standby and mode control over APB and pins
// Assumes: Tick of four pclk cycles, settle of two ticks
// Notes:   Sequencer state driven by the bench
module standby_buck_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_req = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0, prdata, q;
  logic                pready, pslverr, e, standby_pin, uo_cmd, pll_en, uo_mh;
  logic [1:0]          pums = 2'h2;
  logic [29:0]         sp_out;
  logic [5:0]          regul = 6'h00, slot = 6'h00, reg_en, use_sp;
  logic [11:0]         reg_mode;
  sbmc_pkg::sbmc_pwr_e pwr_state = sbmc_pkg::PWR_OFF;
  int                  fails = 0, comparisons = 0, n;
  always #2 pclk = ~pclk;
  sbmc_top #(.TICK_CYCLES(4), .SETTLE_TICKS(2), .SETPT_TABLE(20'h8a4e2)) i_sbmc_top (.pclk(pclk),
    .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standby_pin(standby_pin), .powerup_mode_select_pins(pums), .reg_in_regulation(regul),
    .pwr_state(pwr_state), .startup_slot(slot), .user_off_cmd(uo_cmd), .user_off_memhold(uo_mh),
    .pll_enable(pll_en),
    .reg_enable(reg_en), .reg_discharge(), .reg_use_standby_setpoint(use_sp), .reg_mode(reg_mode),
    .regulator_standby_setpoint(sp_out));
  sbmc_host_model i_sbmc_host_model (.pclk(pclk), .sleep_req(sleep_req), .standby_pin(standby_pin));
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic settle(input int c);
    repeat (c) @(negedge pclk);
  endtask : settle
  // One APB transfer, data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 16)
    begin
      k++;
      @(posedge pclk);
    end
    if (k == 16)
    begin
      fails++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_pll(input logic lvl);
    n = 0;
    while (pll_en !== lvl && n < 100)
    begin
      @(negedge pclk);
      n++;
    end
    if (n == 100)
    begin
      fails++;
      stop_test();
    end
  endtask : wait_pll
  task automatic t_reset();
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h10, q);
    apb(1'b0, 8'h08, 32'h0);
    chk("mode reset", 32'h00888888, q);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {q[30:0], e});
    // Strap 2 selects entry 5'h09 of the table given above
    apb(1'b0, 8'h10, 32'h0);
    chk("setpt reset", {2'h0, {6{5'h09}}}, q);
    chk("setpt pins", {2'h0, {6{5'h09}}}, {2'h0, sp_out});
  endtask : t_reset
  // Sequencer start: held modes, slot pulse, ramp, final mode
  task automatic t_start(input logic [11:0] held, input logic [11:0] first);
    @(posedge pclk);
    pwr_state <= sbmc_pkg::PWR_STARTUP;
    regul <= 6'h00;
    settle(2);
    chk("held modes", held, reg_mode);
    @(posedge pclk);
    slot <= 6'h3f;
    @(posedge pclk);
    slot <= 6'h00;
    settle(1);
    chk("slot modes", first, reg_mode);
    @(posedge pclk);
    regul <= 6'h3f;
    settle(60);
    chk("start mode", 12'hfff, reg_mode);
  endtask : t_start
  task automatic t_codes(input logic [31:0] tbl);
    logic [1:0] m;
    for (int c = 0; c < 16; c++)
    begin
      m = tbl[2*c +: 2];
      apb(1'b1, 8'h08, {8'h0, {6{c[3:0]}}});
      settle(16); // Room for soft-start from off
      apb(1'b0, 8'h14, 32'h0);
      chk("actual", {10'h0, {6{|m}}, 4'h0, {6{m}}}, q);
      apb(1'b0, 8'h08, 32'h0);
      chk("mode read", {8'h0, {6{c[3:0]}}}, q);
    end
  endtask : t_codes
  task automatic t_pol();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      sleep_req <= k[1];
      apb(1'b1, 8'h00, {31'h0, k[0]});
      settle(16);
      apb(1'b0, 8'h04, 32'h0);
      chk("decoded", {31'h0, k[1] ^ k[0]}, {31'h0, q[0]});
    end
  endtask : t_pol
  task automatic t_dly();
    for (int d = 0; d < 4; d++)
    begin
      @(posedge pclk);
      sleep_req <= 1'b0;
      apb(1'b1, 8'h00, 32'h2 | (d << 4));
      settle(20);
      @(posedge pclk);
      sleep_req <= 1'b1;
      wait_pll(1'b0);
      chk("entry delay", 1, n >= (d == 0 ? 2 : 4 * d - 2) && n <= 4 * d + 10);
      @(posedge pclk);
      sleep_req <= 1'b0;
      wait_pll(1'b1);
      chk("exit delay", 1, n <= 10);
    end
  endtask : t_dly
  task automatic t_ign();
    @(posedge pclk);
    pwr_state <= sbmc_pkg::PWR_WATCHDOG;
    sleep_req <= 1'b1;
    settle(30);
    chk("watchdog pll", 1, pll_en);
    @(posedge pclk);
    pwr_state <= sbmc_pkg::PWR_ON;
    wait_pll(1'b0);
    chk("on pll", 1, n <= 22);
  endtask : t_ign
  // Low-power off states while standby is active, then restart
  task automatic t_lpoff();
    apb(1'b1, 8'h08, 32'h00888888);
    apb(1'b1, 8'h0c, 32'h3207);
    apb(1'b1, 8'h00, 32'h0e);
    apb(1'b0, 8'h00, 32'h0);
    chk("request reads", 32'h0a, q);
    chk("memhold target", 1, uo_mh);
    @(posedge pclk);
    pwr_state <= sbmc_pkg::PWR_USEROFF;
    settle(8);
    chk("useroff modes", 12'h504, reg_mode);
    chk("useroff setpt", 6'h32, use_sp & 6'h32);
    @(posedge pclk);
    pwr_state <= sbmc_pkg::PWR_ON;
    settle(8);
    @(posedge pclk);
    pwr_state <= sbmc_pkg::PWR_MEMHOLD;
    settle(8);
    chk("memhold modes", 12'h015, reg_mode);
    t_start(12'h015, 12'h57f);
    chk("startup pll", 1, pll_en);
  endtask : t_lpoff
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start(12'h000, 12'h555);
    @(posedge pclk);
    pwr_state <= sbmc_pkg::PWR_ON;
    t_codes(32'h4b032b48);
    apb(1'b1, 8'h00, 32'h01);
    settle(16);
    t_codes(32'h45033800);
    t_pol();
    apb(1'b1, 8'h08, 32'h00ffffff);
    t_dly();
    t_ign();
    t_lpoff();
    stop_test();
  end
endmodule : standby_buck_mode_control_bench
